/* File: hw/cpu_pkg.sv */
// shared constants, types and encodings for the background-halt decode block
package cpu_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned REG_ADDR_W = 4;

    // condition_flags bit positions
    localparam int unsigned FLAG_V = 7;
    localparam int unsigned FLAG_H = 4;
    localparam int unsigned FLAG_I = 3;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_C = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h08;
    localparam logic [7:0] FLAGS_MASK = 8'h9F;

    // opcodes and opcode nibbles
    localparam logic [7:0] OPC_BACKGROUND_HALT = 8'h82;
    localparam logic [7:0] OPC_BRANCH_CARRY_CLEAR = 8'h24;
    localparam logic [7:0] OPC_STACK_ADJUST = 8'hA7;
    localparam logic [7:0] OPC_INDEX_ADJUST = 8'hAF;
    localparam logic [7:0] OPC_STACK_PREFIX = 8'h9E;
    localparam logic [3:0] LO_ADD_CARRY = 4'h9;
    localparam logic [3:0] LO_ADD = 4'hB;
    localparam logic [3:0] LO_AND = 4'h4;
    localparam logic [3:0] LO_SHIFT_LEFT = 4'h8;
    localparam logic [3:0] LO_SHIFT_RIGHT = 4'h7;
    localparam logic [3:0] HI_LITERAL = 4'hA;
    localparam logic [3:0] HI_DIRECT = 4'hB;
    localparam logic [3:0] HI_FULL = 4'hC;
    localparam logic [3:0] HI_OFF16 = 4'hD;
    localparam logic [3:0] HI_OFF8 = 4'hE;
    localparam logic [3:0] HI_PLAIN = 4'hF;
    localparam logic [3:0] HI_SH_DIRECT = 4'h3;
    localparam logic [3:0] HI_SH_ACCUM = 4'h4;
    localparam logic [3:0] HI_SH_INDEX = 4'h5;
    localparam logic [3:0] HI_SH_OFF8 = 4'h6;
    localparam logic [3:0] HI_SH_PLAIN = 4'h7;

    localparam logic [7:0] DIRECT_PAGE_HI = 8'h00;
    localparam logic [15:0] WORD_STEP = 16'h0001;
    localparam logic [15:0] ADDR_ZERO = 16'h0000;

    // register map, one byte each
    localparam logic [3:0] REG_FLAGS = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_ACCUM = 4'h3;
    localparam logic [3:0] REG_PC_HI = 4'h4;
    localparam logic [3:0] REG_PC_LO = 4'h5;
    localparam int unsigned CTRL_DEBUG_EN = 0;
    localparam int unsigned STATUS_BG = 0;
    localparam int unsigned STATUS_STEP = 1;

    typedef enum logic [1:0] {
        cmd_none = 2'b00,
        resume_cmd = 2'b01,
        single_step_cmd = 2'b10,
        tagged_resume_cmd = 2'b11
    } debug_cmd_t;

    typedef enum logic [3:0] {
        no_operand_form, literal_operand_form, direct_page, full_addr, indexed_plain,
        indexed_off8, indexed_off16, stack_rel_off8, stack_rel_off16, relative_form
    } addr_mode_t;

    typedef enum logic [2:0] {
        op_add_carry, op_add, op_and, op_shift_left, op_shift_right
    } alu_op_t;

    typedef enum logic [2:0] {
        k_none, k_alu, k_shift, k_stack_adjust, k_index_adjust, k_branch, k_halt
    } instr_kind_t;

    // gray codes along fetch -> wait -> decode -> oper1 -> oper2 -> addr -> exec
    typedef enum logic [3:0] {
        st_fetch = 4'b0000,
        st_wait = 4'b0001,
        st_decode = 4'b0011,
        st_oper1 = 4'b0010,
        st_oper2 = 4'b0110,
        st_addr = 4'b0111,
        st_exec = 4'b0101,
        st_halt = 4'b0100
    } state_t;

endpackage

/* File: hw/core_if.sv */
// carrier between the sequencer, the arithmetic unit and the address former
`timescale 1ns/10ps
`default_nettype none
interface core_if;
    import cpu_pkg::*;
    alu_op_t alu_op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] flags_in;
    logic [7:0] result;
    logic [7:0] flags_out;
    addr_mode_t mode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [15:0] ea;
    modport alu (input alu_op, a, b, flags_in, output result, flags_out);
    modport ea_calc (input mode, byte1, byte2, hx, sp, pc, output ea);
    modport core (output alu_op, a, b, flags_in, mode, byte1, byte2, hx, sp, pc,
        input result, flags_out, ea);
endinterface
`default_nettype wire

/* File: hw/cpu_alu.sv */
// accumulator arithmetic, logic and shifts with flag update
`timescale 1ns/10ps
`default_nettype none
module cpu_alu (
    core_if.alu io
);
    import cpu_pkg::*;

    logic [8:0] sum;
    logic [4:0] half;
    logic carry_in;

    always_comb begin
        carry_in = (io.alu_op == op_add_carry) ? io.flags_in[FLAG_C] : 1'b0;
        sum = {1'b0, io.a} + {1'b0, io.b} + {8'h00, carry_in};
        half = {1'b0, io.a[3:0]} + {1'b0, io.b[3:0]} + {4'h0, carry_in};
        io.flags_out = io.flags_in;
        io.result = io.a;
        case (io.alu_op)
            op_add_carry, op_add: begin
                io.result = sum[7:0];
                io.flags_out[FLAG_C] = sum[8];
                io.flags_out[FLAG_H] = half[4];
                io.flags_out[FLAG_V] = (io.a[7] & io.b[7] & ~sum[7]) |
                    (~io.a[7] & ~io.b[7] & sum[7]);
            end
            op_and: begin
                io.result = io.a & io.b;
                io.flags_out[FLAG_V] = 1'b0;
            end
            op_shift_left: begin
                io.result = {io.a[6:0], 1'b0};
                io.flags_out[FLAG_C] = io.a[7];
            end
            op_shift_right: begin
                io.result = {io.a[7], io.a[7:1]};
                io.flags_out[FLAG_C] = io.a[0];
            end
            default: begin
                io.result = io.a;
            end
        endcase
        io.flags_out[FLAG_N] = io.result[7];
        io.flags_out[FLAG_Z] = (io.result == 8'h00);
        if (io.alu_op == op_shift_left || io.alu_op == op_shift_right) begin
            io.flags_out[FLAG_V] = io.result[7] ^ io.flags_out[FLAG_C];
        end
    end

endmodule
`default_nettype wire

/* File: hw/cpu_ea.sv */
// effective address former for every operand form
`timescale 1ns/10ps
`default_nettype none
module cpu_ea (
    core_if.ea_calc io
);
    import cpu_pkg::*;

    logic [15:0] sext;
    logic [15:0] off8;
    logic [15:0] off16;

    always_comb begin
        sext = {{8{io.byte1[7]}}, io.byte1};
        off8 = {8'h00, io.byte1};
        off16 = {io.byte1, io.byte2};
        case (io.mode)
            direct_page: io.ea = {DIRECT_PAGE_HI, io.byte1};
            full_addr: io.ea = off16;
            indexed_plain: io.ea = io.hx;
            indexed_off8: io.ea = io.hx + off8;
            indexed_off16: io.ea = io.hx + off16; // wraps at 64K
            stack_rel_off8: io.ea = io.sp + off8;
            stack_rel_off16: io.ea = io.sp + off16;
            relative_form: io.ea = io.pc + sext; // pc already past the offset
            default: io.ea = ADDR_ZERO;
        endcase
    end

endmodule
`default_nettype wire

/* File: hw/cpu_decode_background_halt.sv */
// instruction sequencer: fetch, decode, operand addressing, execute, background halt
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - executing the background-halt opcode stops user code and enters background mode
// - background mode is left only by reset or a resume, step or tagged-resume command
// - a halt opcode planted as breakpoint halts the program on reaching it
// - opcode 82, no operand, halts only with the debug enable bit set
// - flags: V bit 7, H bit 4, I bit 3, N bit 2, Z bit 1, C bit 0
// - two-byte operands: upper byte at the address, lower byte at the next
// - direct page addresses carry a forced zero upper byte
// - full addresses are two bytes, upper byte first, covering 64K
// - relative target is next instruction address plus signed 8-bit offset
// - indexed adds none, unsigned 8 or 16 bit offset; stack adds 8 or 16
// - 16-bit offsets wrap modulo 64K, acting signed or unsigned alike
// - post-increment forms bump the index after fetch; only for compare and move
// - bit numbers select one bit 0 to 7 of the addressed byte
// - stack and index adjust sign-extend the literal, add it, leave flags alone
// - branch on carry clear, opcode 24, branches when carry is zero, flags kept
module cpu_decode_background_halt #(
    parameter logic [15:0] RESET_PC = 16'h0000,
    parameter logic [15:0] RESET_SP = 16'h00FF
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    output logic [cpu_pkg::ADDR_W-1:0] mem_addr_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [cpu_pkg::DATA_W-1:0] mem_wdata_o,
    input wire logic [cpu_pkg::DATA_W-1:0] mem_rdata_i,
    input wire logic debug_cmd_valid_i,
    input wire cpu_pkg::debug_cmd_t debug_cmd_i,
    output logic background_active_o,
    input wire logic [cpu_pkg::REG_ADDR_W-1:0] reg_addr_i,
    input wire logic [cpu_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [cpu_pkg::DATA_W-1:0] reg_rdata_o
);
    import cpu_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    function automatic instr_kind_t decode_kind(input logic [7:0] opc, input logic pre);
        logic [3:0] lo;
        lo = opc[3:0];
        decode_kind = k_none;
        if (!pre && opc == OPC_BACKGROUND_HALT) begin
            decode_kind = k_halt;
        end else if (!pre && opc == OPC_BRANCH_CARRY_CLEAR) begin
            decode_kind = k_branch;
        end else if (!pre && opc == OPC_STACK_ADJUST) begin
            decode_kind = k_stack_adjust;
        end else if (!pre && opc == OPC_INDEX_ADJUST) begin
            decode_kind = k_index_adjust;
        end else if (lo == LO_ADD_CARRY || lo == LO_ADD || lo == LO_AND) begin
            if (pre ? (opc[7:4] == HI_OFF16 || opc[7:4] == HI_OFF8)
                    : (opc[7:4] >= HI_LITERAL)) begin
                decode_kind = k_alu;
            end
        end else if (lo == LO_SHIFT_LEFT || lo == LO_SHIFT_RIGHT) begin
            if (pre ? (opc[7:4] == HI_SH_OFF8)
                    : (opc[7:4] >= HI_SH_DIRECT && opc[7:4] <= HI_SH_PLAIN)) begin
                decode_kind = k_shift;
            end
        end
    endfunction

    function automatic addr_mode_t decode_mode(input logic [7:0] opc, input logic pre);
        logic [3:0] hi;
        hi = opc[7:4];
        decode_mode = no_operand_form;
        if (pre) begin
            // prefixed: stack-relative forms
            decode_mode = (hi == HI_OFF16) ? stack_rel_off16 : stack_rel_off8;
        end else if (opc == OPC_BRANCH_CARRY_CLEAR) begin
            decode_mode = relative_form;
        end else if (opc == OPC_STACK_ADJUST || opc == OPC_INDEX_ADJUST) begin
            decode_mode = literal_operand_form;
        end else begin
            case (hi)
                HI_LITERAL: decode_mode = literal_operand_form;
                HI_DIRECT, HI_SH_DIRECT: decode_mode = direct_page;
                HI_FULL: decode_mode = full_addr;
                HI_OFF16: decode_mode = indexed_off16;
                HI_OFF8, HI_SH_OFF8: decode_mode = indexed_off8;
                HI_PLAIN, HI_SH_PLAIN: decode_mode = indexed_plain;
                default: decode_mode = no_operand_form;
            endcase
        end
    endfunction

    function automatic logic [1:0] operand_bytes(input addr_mode_t m);
        case (m)
            full_addr, indexed_off16, stack_rel_off16: operand_bytes = 2'd2;
            no_operand_form, indexed_plain: operand_bytes = 2'd0;
            default: operand_bytes = 2'd1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // reset release

    logic reset_meta;
    logic rst_n;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reset_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            reset_meta <= 1'b1;
            rst_n <= reset_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // programmer state and datapath

    state_t state;
    state_t after;
    instr_kind_t kind;
    addr_mode_t mode;
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] accum;
    logic [7:0] condition_flags;
    logic [15:0] hx;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [15:0] ea_reg;
    logic prefix;
    logic debug_enable;
    logic step_pending;
    logic halt_after;
    logic [15:0] sext_lit;
    logic mem_operand;

    core_if io ();

    cpu_alu u_alu (
        .io(io.alu)
    );

    cpu_ea u_ea (
        .io(io.ea_calc)
    );

    assign sext_lit = {{8{byte1[7]}}, byte1};
    assign mem_operand = (mode != literal_operand_form) && (mode != no_operand_form);

    always_comb begin
        io.mode = mode;
        io.byte1 = byte1;
        io.byte2 = byte2;
        io.hx = hx;
        io.sp = sp;
        io.pc = pc;
        io.flags_in = condition_flags;
        io.b = (mode == literal_operand_form) ? byte1 : mem_rdata_i;
        io.a = accum;
        if (kind == k_shift) begin
            if (mem_operand) begin
                io.a = mem_rdata_i;
            end else if (opcode[7:4] == HI_SH_INDEX) begin
                io.a = hx[7:0];
            end
        end
        case (opcode[3:0])
            LO_ADD_CARRY: io.alu_op = op_add_carry;
            LO_ADD: io.alu_op = op_add;
            LO_AND: io.alu_op = op_and;
            LO_SHIFT_LEFT: io.alu_op = op_shift_left;
            default: io.alu_op = op_shift_right;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= st_fetch;
            after <= st_fetch;
            kind <= k_none;
            mode <= no_operand_form;
            opcode <= 8'h00;
            byte1 <= 8'h00;
            byte2 <= 8'h00;
            accum <= 8'h00;
            hx <= ADDR_ZERO;
            sp <= RESET_SP;
            pc <= RESET_PC;
            ea_reg <= ADDR_ZERO;
            prefix <= 1'b0;
            step_pending <= 1'b0;
            halt_after <= 1'b0;
            background_active_o <= 1'b0;
            mem_addr_o <= ADDR_ZERO;
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
            mem_wdata_o <= 8'h00;
        end else begin
            mem_rd_o <= 1'b0;
            mem_wr_o <= 1'b0;
            case (state)
                st_fetch: begin
                    if (halt_after) begin
                        // single step finished one instruction
                        halt_after <= 1'b0;
                        background_active_o <= 1'b1;
                        state <= st_halt;
                    end else begin
                        mem_addr_o <= pc;
                        mem_rd_o <= 1'b1;
                        pc <= pc + WORD_STEP;
                        prefix <= 1'b0;
                        after <= st_decode;
                        state <= st_wait;
                    end
                end
                st_wait: begin
                    state <= after;
                end
                st_decode: begin
                    if (!prefix && mem_rdata_i == OPC_STACK_PREFIX) begin
                        prefix <= 1'b1;
                        mem_addr_o <= pc;
                        mem_rd_o <= 1'b1;
                        pc <= pc + WORD_STEP;
                        after <= st_decode;
                        state <= st_wait;
                    end else begin
                        opcode <= mem_rdata_i;
                        kind <= decode_kind(mem_rdata_i, prefix);
                        mode <= decode_mode(mem_rdata_i, prefix);
                        halt_after <= step_pending;
                        step_pending <= 1'b0;
                        if (decode_kind(mem_rdata_i, prefix) == k_halt) begin
                            // planted breakpoints land here too
                            background_active_o <= debug_enable;
                            state <= debug_enable ? st_halt : st_fetch;
                        end else if (decode_kind(mem_rdata_i, prefix) == k_none) begin
                            // opcodes outside this block run as no-ops
                            state <= st_fetch;
                        end else if (operand_bytes(decode_mode(mem_rdata_i, prefix)) == 2'd0) begin
                            state <= st_addr;
                        end else begin
                            mem_addr_o <= pc;
                            mem_rd_o <= 1'b1;
                            pc <= pc + WORD_STEP;
                            after <= st_oper1;
                            state <= st_wait;
                        end
                    end
                end
                st_oper1: begin
                    byte1 <= mem_rdata_i; // upper byte comes first
                    if (operand_bytes(mode) == 2'd2) begin
                        mem_addr_o <= pc;
                        mem_rd_o <= 1'b1;
                        pc <= pc + WORD_STEP;
                        after <= st_oper2;
                        state <= st_wait;
                    end else begin
                        state <= st_addr;
                    end
                end
                st_oper2: begin
                    byte2 <= mem_rdata_i; // lower byte from the next address
                    state <= st_addr;
                end
                st_addr: begin
                    ea_reg <= io.ea;
                    case (kind)
                        k_stack_adjust: begin
                            sp <= sp + sext_lit;
                            state <= st_fetch;
                        end
                        k_index_adjust: begin
                            hx <= hx + sext_lit;
                            state <= st_fetch;
                        end
                        k_branch: begin
                            if (!condition_flags[FLAG_C]) begin
                                pc <= io.ea;
                            end
                            state <= st_fetch;
                        end
                        default: begin
                            if (mem_operand) begin
                                mem_addr_o <= io.ea;
                                mem_rd_o <= 1'b1;
                                after <= st_exec;
                                state <= st_wait;
                            end else begin
                                state <= st_exec;
                            end
                        end
                    endcase
                end
                st_exec: begin
                    // no form decoded here post-increments, so hx only moves by index adjust or an index-register shift
                    if (kind == k_shift && mem_operand) begin
                        mem_addr_o <= ea_reg;
                        mem_wdata_o <= io.result;
                        mem_wr_o <= 1'b1;
                    end else if (kind == k_shift && opcode[7:4] == HI_SH_INDEX) begin
                        hx[7:0] <= io.result;
                    end else begin
                        accum <= io.result;
                    end
                    state <= st_fetch;
                end
                st_halt: begin
                    // only a host command leaves background mode
                    if (debug_cmd_valid_i && debug_cmd_i != cmd_none) begin
                        step_pending <= (debug_cmd_i == single_step_cmd);
                        background_active_o <= 1'b0;
                        state <= st_fetch;
                    end
                end
                default: begin
                    state <= st_fetch;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // condition flags: an executing instruction wins over a software write

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            condition_flags <= FLAGS_RESET;
        end else if (state == st_exec) begin
            condition_flags <= io.flags_out & FLAGS_MASK;
        end else if (reg_wr_i && reg_addr_i == REG_FLAGS) begin
            condition_flags <= reg_wdata_i & FLAGS_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register port

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            debug_enable <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
            debug_enable <= reg_wdata_i[CTRL_DEBUG_EN];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                REG_FLAGS: reg_rdata_o <= condition_flags;
                REG_CTRL: reg_rdata_o <= {7'h00, debug_enable};
                REG_STATUS: reg_rdata_o <= {6'h00, step_pending | halt_after,
                    background_active_o};
                REG_ACCUM: reg_rdata_o <= accum;
                REG_PC_HI: reg_rdata_o <= pc[15:8];
                REG_PC_LO: reg_rdata_o <= pc[7:0];
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule
`default_nettype wire

/* File: verification/cpu_mem_model.sv */
// program memory partner: one-cycle read answer, no wait states
`timescale 1ns/10ps
`default_nettype none
module cpu_mem_model (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] m [0:65535];
    // outside the answer cycle the bus shows the inverse, never the last value
    always @(posedge clk_i) begin
        rdata_o <= rd_i ? m[addr_i] : ~rdata_o;
        if (wr_i)
            m[addr_i] <= wdata_i;
    end
endmodule
`default_nettype wire

/* File: verification/cpu_decode_chk.sv */
// port-level assertions for the background-halt sequencer
`timescale 1ns/10ps
`default_nettype none
module cpu_decode_chk (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic mem_rd_o,
    input wire logic debug_cmd_valid_i,
    input wire cpu_pkg::debug_cmd_t debug_cmd_i,
    input wire logic background_active_o,
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o
);
    import cpu_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic go;
    assign go = debug_cmd_valid_i && debug_cmd_i != cmd_none;
    rd_pulse_a: assert property (mem_rd_o |=> !mem_rd_o)
        else $error("fetch strobe too long");
    halt_quiet_a: assert property (background_active_o |-> !mem_rd_o)
        else $error("fetch while halted");
    // a step halt lands up to five cycles after the last read of its instruction
    halt_entry_a: assert property ($rose(background_active_o) |-> $past(mem_rd_o, 2) ||
        $past(mem_rd_o, 3) || $past(mem_rd_o, 4) || $past(mem_rd_o, 5))
        else $error("halt not tied to an opcode fetch");
    halt_hold_a: assert property (background_active_o && !go |=> background_active_o)
        else $error("background mode left without command");
    cmd_leave_a: assert property (background_active_o && go |=> !background_active_o)
        else $error("command did not resume");
    resume_fetch_a: assert property ($fell(background_active_o) |-> ##[0:1] mem_rd_o)
        else $error("no fetch after resume");
    flag_gap_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == REG_FLAGS
        |-> reg_rdata_o[6:5] == 2'b00)
        else $error("unused flag bits set");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside answer cycle");
    cover property ($rose(background_active_o));
    cover property ($fell(background_active_o));
    cover property (reg_rd_i ##1 reg_rdata_o != 8'h00);
endmodule
bind cpu_decode_background_halt cpu_decode_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .mem_rd_o(mem_rd_o), .debug_cmd_valid_i(debug_cmd_valid_i), .debug_cmd_i(debug_cmd_i),
    .background_active_o(background_active_o), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o));
`default_nettype wire

/* File: verification/cpu_decode_background_halt_tb.sv */
// random program runs through index adjust, shift to memory, add, branch and halt
`timescale 1ns/10ps
`default_nettype none
module cpu_decode_background_halt_tb;
    import cpu_pkg::*;
    logic clk_i = 0, reset_n_i = 0, mem_rd_o, mem_wr_o, reg_wr_i = 0, reg_rd_i = 0;
    logic debug_cmd_valid_i = 0, background_active_o;
    logic [15:0] mem_addr_o, seed = 16'h19BA;
    logic [7:0] mem_wdata_o, mem_rdata_i, reg_wdata_i = 0, reg_rdata_o, ii, rr, v;
    logic [3:0] reg_addr_i = 0;
    debug_cmd_t debug_cmd_i = cmd_none;
    int mismatches = 0, check_count = 0;
    always #20 clk_i = ~clk_i;
    cpu_decode_background_halt u_dut (.clk_i, .reset_n_i, .mem_addr_o, .mem_rd_o, .mem_wr_o,
        .mem_wdata_o, .mem_rdata_i, .debug_cmd_valid_i, .debug_cmd_i, .background_active_o,
        .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
    cpu_mem_model u_mem (.clk_i, .rd_i(mem_rd_o), .wr_i(mem_wr_o), .addr_i(mem_addr_o),
        .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
    function logic [15:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction
    task chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task reg_rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
        @(posedge clk_i) reg_rd_i <= 0;
        #1 chk(reg_rdata_o === e, "register read");
    endtask
    task send(input debug_cmd_t c);
        @(posedge clk_i) {debug_cmd_valid_i, debug_cmd_i} <= {1'b1, c};
        @(posedge clk_i) debug_cmd_valid_i <= 0;
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #100us mismatches++;
        report_and_stop();
    end
    initial begin
        for (int it = 0; it < 4; it++) begin
            reset_n_i <= 0;
            ii = {rnd() >> 8} | 8'h40;
            rr = 8'h10 | rnd() & 8'h0F;
            v = rnd();
            for (int a = 0; a < 65536; a++) u_mem.m[a] = 8'h9D;
            {u_mem.m[0], u_mem.m[1], u_mem.m[2], u_mem.m[3], u_mem.m[4], u_mem.m[5]} =
                {8'hAF, ii, 8'h78, 8'hFB, OPC_BRANCH_CARRY_CLEAR, rr};
            u_mem.m[{{8{ii[7]}}, ii}] = v;
            u_mem.m[16'h0006 + rr] = OPC_BACKGROUND_HALT;
            repeat (12) @(posedge clk_i);
            reset_n_i <= 1;
            repeat (3) @(posedge clk_i);
            reg_wr_i <= 1;
            {reg_addr_i, reg_wdata_i} <= {REG_CTRL, 7'h00, it != 0};
            @(posedge clk_i) reg_wr_i <= 0;
            send(resume_cmd);
            for (int n = 0; n < 100 && background_active_o !== 1'b1; n++) @(posedge clk_i);
            #1 chk(background_active_o === (it != 0), "halt state");
            if (it != 0) begin
                chk(u_mem.m[{{8{ii[7]}}, ii}] === {v[6:0], 1'b0}, "shifted byte");
                reg_rd(REG_ACCUM, {v[6:0], 1'b0});
                reg_rd(REG_FLAGS, {5'b0000_1, v[6], v[6:0] == 7'h00, 1'b0});
                reg_rd(4'hF, 8'h00);
                send(debug_cmd_t'(it));
                #1 chk(background_active_o === 1'b0, "resume");
                if (it == 2) begin
                    repeat (8) @(posedge clk_i);
                    #1 chk(background_active_o === 1'b1, "step halt");
                end
            end
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
